// File: twsl_pkg.sv
// constants, types and register layout of the two-wire slave block
package twsl_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [1:0] OFS_OWN_ADDR = 2'h0;
  localparam logic [1:0] OFS_CONTROL  = 2'h1;
  localparam logic [1:0] OFS_STATUS   = 2'h2;
  localparam logic [1:0] OFS_DATA     = 2'h3;

  localparam int CTL_FLAG  = 7;
  localparam int CTL_ACK   = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP  = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IRQEN = 0;

  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [6:0] GC_ADDR  = 7'h00;
  localparam logic [7:0] CODE_MASK = 8'hf8;

  // ****************************************
  // status codes
  // ****************************************
  localparam logic [7:0] ST_SR_OWN      = 8'h60;
  localparam logic [7:0] ST_SR_OWN_ARB  = 8'h68;
  localparam logic [7:0] ST_SR_GC       = 8'h70;
  localparam logic [7:0] ST_SR_GC_ARB   = 8'h78;
  localparam logic [7:0] ST_SR_DAT_ACK  = 8'h80;
  localparam logic [7:0] ST_SR_DAT_NACK = 8'h88;
  localparam logic [7:0] ST_GC_DAT_ACK  = 8'h90;
  localparam logic [7:0] ST_GC_DAT_NACK = 8'h98;
  localparam logic [7:0] ST_SR_STOP     = 8'ha0;
  localparam logic [7:0] ST_ST_OWN      = 8'ha8;
  localparam logic [7:0] ST_ST_OWN_ARB  = 8'hb0;
  localparam logic [7:0] ST_ST_DAT_ACK  = 8'hb8;
  localparam logic [7:0] ST_ST_DAT_NACK = 8'hc0;
  localparam logic [7:0] ST_ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] ST_NONE        = 8'hf8;

  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_END   = 4'h9;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_ADDR     = 3'b001,
    S_ADDR_ACK = 3'b010,
    S_RX       = 3'b011,
    S_RX_ACK   = 3'b100,
    S_TX       = 3'b101,
    S_TX_ACK   = 3'b110,
    S_STRETCH  = 3'b111
  } twsl_fsm_type;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } twsl_reg_req_type;

  typedef struct packed {
    twsl_fsm_type fsm;
    logic [3:0]   cnt;
    logic [7:0]   sh;
    logic [7:0]   own;
    logic         flag;
    logic         ack_en;
    logic         start_request_bit;
    logic         stop_request_bit;
    logic         wcol;
    logic         en;
    logic         irq_en;
    logic [1:0]   presc;
    logic [7:0]   status;
    logic [7:0]   data;
    logic         rw;
    logic         gc;
    logic         ack_next;
    logic         last;
    logic         mst_ack;
    logic         sda_drv;
    logic         scl_hold;
    logic         busy;
    logic         start_pend;
    logic         start_go;
    logic         wake;
    logic [7:0]   rdata;
    logic         scl_s1;
    logic         scl_s2;
    logic         scl_s3;
    logic         sda_s1;
    logic         sda_s2;
    logic         sda_s3;
  } twsl_state_type;

  localparam twsl_state_type STATE_RST = '{
    fsm: S_IDLE, own: OWN_RST, status: ST_NONE, data: DATA_RST,
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
    default: '0};

endpackage

// File: twsl_slave.sv
// two-wire bus slave with receive and transmit modes and register port
`timescale 1ns/1ps
module twsl_slave (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire twsl_pkg::twsl_reg_req_type reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      arb_lost,
  input  wire logic                      sleep_deep,
  output logic                           wake_req,
  output logic                           start_issue
);

  twsl_pkg::twsl_state_type r;
  twsl_pkg::twsl_state_type n;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       clr;
  logic       cmd;
  logic       flag_set;
  logic [7:0] byte_in;
  logic       own_hit;
  logic       gc_hit;
  logic [7:0] code;

  // ****************************************
  // bus line events
  // ****************************************
  assign scl_rise  = r.scl_s2 & ~r.scl_s3;
  assign scl_fall  = ~r.scl_s2 & r.scl_s3;
  assign start_det = r.scl_s2 & r.scl_s3 & r.sda_s3 & ~r.sda_s2;
  assign stop_det  = r.scl_s2 & r.scl_s3 & ~r.sda_s3 & r.sda_s2;
  assign byte_in   = {r.sh[6:0], r.sda_s2};
  assign code      = r.status & twsl_pkg::CODE_MASK;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    n.scl_s1   = scl_in;
    n.scl_s2   = r.scl_s1;
    n.scl_s3   = r.scl_s2;
    n.sda_s1   = sda_in;
    n.sda_s2   = r.sda_s1;
    n.sda_s3   = r.sda_s2;
    n.start_go = 1'b0;
    n.rdata    = '0;
    flag_set   = 1'b0;
    own_hit    = 1'b0;
    gc_hit     = 1'b0;
    clr        = 1'b0;

    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        twsl_pkg::OFS_OWN_ADDR: begin
          n.own = reg_req.wdata;
        end
        twsl_pkg::OFS_CONTROL: begin
          clr      = reg_req.wdata[twsl_pkg::CTL_FLAG];
          n.ack_en = reg_req.wdata[twsl_pkg::CTL_ACK];
          n.start_request_bit    = reg_req.wdata[twsl_pkg::CTL_START];
          n.stop_request_bit    = reg_req.wdata[twsl_pkg::CTL_STOP];
          n.en     = reg_req.wdata[twsl_pkg::CTL_EN];
          n.irq_en = reg_req.wdata[twsl_pkg::CTL_IRQEN];
        end
        twsl_pkg::OFS_STATUS: begin
          n.presc = reg_req.wdata[1:0];
        end
        twsl_pkg::OFS_DATA: begin
          if (r.flag) begin
            n.data = reg_req.wdata;
            n.wcol = 1'b0;
          end else begin
            n.wcol = 1'b1;
          end
        end
        default: begin
          n.presc = r.presc;
        end
      endcase
    end
    cmd = clr & r.flag;

    // register reads, data in the following cycle only
    if (reg_req.rd) begin
      case (reg_req.addr)
        twsl_pkg::OFS_OWN_ADDR: n.rdata = r.own;
        twsl_pkg::OFS_CONTROL:  n.rdata = {r.flag, r.ack_en, r.start_request_bit, r.stop_request_bit,
                                           r.wcol, r.en, 1'b0, r.irq_en};
        twsl_pkg::OFS_STATUS:   n.rdata = {code[7:3], 1'b0, r.presc};
        twsl_pkg::OFS_DATA:     n.rdata = r.data;
        default:                n.rdata = '0;
      endcase
    end

    // bus occupancy for a pending start
    if (start_det) begin
      n.busy = 1'b1;
    end else if (stop_det) begin
      n.busy = 1'b0;
    end
    if (r.start_pend && !r.busy && r.en) begin
      n.start_pend = 1'b0;
      n.start_go   = 1'b1;
      n.start_request_bit        = 1'b0;
    end

    // address match, live acknowledge_enable gates recognition
    own_hit = byte_in[7:1] == r.own[7:1];
    gc_hit  = (byte_in[7:1] == twsl_pkg::GC_ADDR) && r.own[0] && !byte_in[0];

    case (r.fsm)
      twsl_pkg::S_IDLE: begin
        n.sda_drv = 1'b0;
        if (start_det) begin
          n.fsm = twsl_pkg::S_ADDR;
          n.cnt = twsl_pkg::BIT_FIRST;
        end
      end
      twsl_pkg::S_ADDR: begin
        if (scl_rise) begin
          n.sh  = byte_in;
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == twsl_pkg::BIT_LAST) begin
            if (n.ack_en && (own_hit || gc_hit)) begin
              n.fsm = twsl_pkg::S_ADDR_ACK;
              n.rw  = byte_in[0];
              n.gc  = gc_hit & ~own_hit;
            end else begin
              n.fsm = twsl_pkg::S_IDLE;
            end
          end
        end
      end
      twsl_pkg::S_ADDR_ACK: begin
        if (scl_fall) begin
          if (r.cnt == twsl_pkg::BIT_ACK) begin
            n.sda_drv = 1'b1;
            n.cnt     = twsl_pkg::BIT_END;
          end else begin
            n.sda_drv  = 1'b0;
            n.scl_hold = 1'b1;
            n.fsm      = twsl_pkg::S_STRETCH;
            flag_set   = 1'b1;
            n.wake     = sleep_deep;
            if (r.rw) begin
              n.status = arb_lost ? twsl_pkg::ST_ST_OWN_ARB : twsl_pkg::ST_ST_OWN;
            end else if (r.gc) begin
              n.status = arb_lost ? twsl_pkg::ST_SR_GC_ARB : twsl_pkg::ST_SR_GC;
            end else begin
              n.status = arb_lost ? twsl_pkg::ST_SR_OWN_ARB : twsl_pkg::ST_SR_OWN;
            end
          end
        end
      end
      twsl_pkg::S_RX: begin
        if (scl_rise) begin
          n.sh  = byte_in;
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == twsl_pkg::BIT_LAST) begin
            n.data = byte_in;
            n.fsm  = twsl_pkg::S_RX_ACK;
          end
        end
      end
      twsl_pkg::S_RX_ACK: begin
        if (scl_fall) begin
          if (r.cnt == twsl_pkg::BIT_ACK) begin
            n.sda_drv = r.ack_next;
            n.cnt     = twsl_pkg::BIT_END;
          end else begin
            n.sda_drv  = 1'b0;
            n.scl_hold = 1'b1;
            n.fsm      = twsl_pkg::S_STRETCH;
            flag_set   = 1'b1;
            if (r.gc) begin
              n.status = r.ack_next ? twsl_pkg::ST_GC_DAT_ACK : twsl_pkg::ST_GC_DAT_NACK;
            end else begin
              n.status = r.ack_next ? twsl_pkg::ST_SR_DAT_ACK : twsl_pkg::ST_SR_DAT_NACK;
            end
          end
        end
      end
      twsl_pkg::S_TX: begin
        if (scl_fall) begin
          if (r.cnt == twsl_pkg::BIT_LAST) begin
            n.sda_drv = 1'b0;
            n.fsm     = twsl_pkg::S_TX_ACK;
          end else begin
            n.sh      = {r.sh[6:0], 1'b1};
            n.sda_drv = ~r.sh[6];
            n.cnt     = r.cnt + 4'h1;
          end
        end
      end
      twsl_pkg::S_TX_ACK: begin
        if (scl_rise) begin
          n.mst_ack = ~r.sda_s2;
        end
        if (scl_fall) begin
          n.scl_hold = 1'b1;
          n.fsm      = twsl_pkg::S_STRETCH;
          flag_set   = 1'b1;
          if (!r.mst_ack) begin
            n.status = twsl_pkg::ST_ST_DAT_NACK;
          end else if (r.last) begin
            n.status = twsl_pkg::ST_ST_LAST_ACK;
          end else begin
            n.status = twsl_pkg::ST_ST_DAT_ACK;
          end
        end
      end
      twsl_pkg::S_STRETCH: begin
        if (cmd) begin
          n.scl_hold = 1'b0;
          n.wake     = 1'b0;
          case (code)
            twsl_pkg::ST_SR_OWN, twsl_pkg::ST_SR_OWN_ARB, twsl_pkg::ST_SR_GC,
            twsl_pkg::ST_SR_GC_ARB, twsl_pkg::ST_SR_DAT_ACK,
            twsl_pkg::ST_GC_DAT_ACK: begin
              n.fsm      = twsl_pkg::S_RX;
              n.cnt      = twsl_pkg::BIT_FIRST;
              n.ack_next = n.ack_en;
            end
            twsl_pkg::ST_ST_OWN, twsl_pkg::ST_ST_OWN_ARB,
            twsl_pkg::ST_ST_DAT_ACK: begin
              n.fsm     = twsl_pkg::S_TX;
              n.cnt     = twsl_pkg::BIT_FIRST;
              n.sh      = n.data;
              n.sda_drv = ~n.data[7];
              n.last    = ~n.ack_en;
            end
            default: begin
              n.fsm        = twsl_pkg::S_IDLE;
              n.sda_drv    = 1'b0;
              n.start_pend = n.start_request_bit;
            end
          endcase
        end
      end
      default: begin
        n.fsm = twsl_pkg::S_IDLE;
      end
    endcase

    // stop or repeated start during a transfer, flagged as stop only in receive mode
    if ((start_det || stop_det) && r.fsm != twsl_pkg::S_STRETCH
        && r.fsm != twsl_pkg::S_IDLE) begin
      n.sda_drv = 1'b0;
      if ((r.fsm == twsl_pkg::S_RX || r.fsm == twsl_pkg::S_RX_ACK)) begin
        n.status   = twsl_pkg::ST_SR_STOP;
        n.fsm      = twsl_pkg::S_STRETCH;
        n.scl_hold = 1'b0;
        flag_set   = 1'b1;
      end else if (start_det) begin
        n.fsm = twsl_pkg::S_ADDR;
        n.cnt = twsl_pkg::BIT_FIRST;
      end else begin
        n.fsm = twsl_pkg::S_IDLE;
      end
    end

    // disabled unit lets go of the bus
    if (!r.en) begin
      n.fsm      = twsl_pkg::S_IDLE;
      n.sda_drv  = 1'b0;
      n.scl_hold = 1'b0;
    end

    n.flag = flag_set | (r.flag & ~clr);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r <= twsl_pkg::STATE_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata   = r.rdata;
  assign scl_out     = 1'b0;
  assign scl_oe      = r.scl_hold;
  assign sda_out     = 1'b0;
  assign sda_oe      = r.sda_drv;
  assign wake_req    = r.wake;
  assign start_issue = r.start_go;

endmodule

// File: twsl_slave_chk.sv
// port checker of the two-wire slave, bound to its top module
`timescale 1ns/1ps
module twsl_slave_chk (
  input wire logic                       clk_sys,
  input wire logic                       arst_n,
  input wire twsl_pkg::twsl_reg_req_type reg_req,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       scl_in,
  input wire logic                       scl_out,
  input wire logic                       scl_oe,
  input wire logic                       sda_in,
  input wire logic                       sda_out,
  input wire logic                       sda_oe,
  input wire logic                       arb_lost,
  input wire logic                       sleep_deep,
  input wire logic                       wake_req,
  input wire logic                       start_issue
);
  logic clr_w;
  // control write that clears the step flag
  assign clr_w = reg_req.wr && reg_req.addr == twsl_pkg::OFS_CONTROL
                 && reg_req.wdata[twsl_pkg::CTL_FLAG];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence clr_s;
    clr_w;
  endsequence
  sequence stretch_clr_s;
    scl_oe ##0 clr_s;
  endsequence
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_lines_open: assert property (!scl_out && !sda_out)
    else $error("line output value not low");
  a_stretch_hold: assert property (scl_oe && !clr_w |=> scl_oe)
    else $error("clock released without flag clear");
  a_stretch_free: assert property (stretch_clr_s |-> ##[1:2] !scl_oe)
    else $error("clock still held after flag clear");
  a_wake_cause: assert property ($rose(wake_req) |-> $past(sleep_deep))
    else $error("wake request outside sleep");
  a_wake_clear: assert property (wake_req ##0 clr_s |-> ##[1:2] !wake_req)
    else $error("wake request kept after flag clear");
  a_sda_edge: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while clock high");
  a_stretch_low: assert property ($rose(scl_oe) |-> !scl_in)
    else $error("stretch started with clock high");
  a_start_free: assert property (start_issue |-> scl_in && sda_in)
    else $error("start launched on busy bus");
  a_start_pulse: assert property (start_issue |=> !start_issue)
    else $error("start pulse longer than one cycle");
endmodule

bind twsl_slave twsl_slave_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .arb_lost(arb_lost),
  .sleep_deep(sleep_deep), .wake_req(wake_req), .start_issue(start_issue));

// File: twsl_bus_master.sv
// behavioural bus master driving the two open-drain lines
`timescale 1ns/1ps
module twsl_bus_master (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // release the clock, then wait out a stretch by the slave of up to 20000 polls of 10 ns
  task automatic rise();
    int n;
    n = 0;
    #40 scl_low = 1'b0;
    while (!scl_line && n < 20000) begin
      #10 n++;
    end
    #80;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low = ~b;
    rise();
    r = sda_line;
    scl_low = 1'b1;
  endtask
  task automatic start();
    sda_low = 1'b1;
    #80 scl_low = 1'b1;
  endtask
  task automatic stop();
    #40 sda_low = 1'b1;
    rise();
    sda_low = 1'b0;
    #160;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic sack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, sack);
  endtask
endmodule

// File: tb_top.sv
// self-checking bench of the two-wire slave
`timescale 1ns/1ps
module tb_top;
  logic                       clk_sys;
  logic                       arst_n;
  twsl_pkg::twsl_reg_req_type reg_req;
  logic [7:0]                 reg_rdata;
  logic                       scl_oe;
  logic                       sda_oe;
  logic                       scl_out;
  logic                       sda_out;
  logic                       scl_low;
  logic                       sda_low;
  logic                       arb_lost;
  logic                       sleep_deep;
  logic                       wake_req;
  logic                       start_issue;
  logic [7:0]                 rx;
  logic                       ak;
  int                         error_cnt;
  int                         cmp_count;
  int                         starts;
  // pulled-up lines
  wire scl_line = !(scl_oe | scl_low);
  wire sda_line = !(sda_oe | sda_low);
  twsl_slave uut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_deep(sleep_deep), .wake_req(wake_req),
    .start_issue(start_issue));
  twsl_bus_master bm (.scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low),
    .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (start_issue === 1'b1) starts <= starts + 1;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
  endtask
  task automatic rc(input string w, input logic [1:0] a, input logic [7:0] mk, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req <= '0;
    #1 chk(w, e, reg_rdata & mk);
  endtask
  task automatic st(input logic [7:0] e);
    rc("status", twsl_pkg::OFS_STATUS, twsl_pkg::CODE_MASK, e);
  endtask
  task automatic wctl(input logic [7:0] d);
    wr(twsl_pkg::OFS_CONTROL, d);
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    bm.xfer(b, 1'b1, rx, ak);
    // the line fall needs the synchroniser and one more edge before flag and status update
    repeat (4) @(posedge clk_sys);
    chk("slave ack", {7'h0, ~e}, {7'h0, ak});
  endtask
  task automatic recv(input logic [7:0] e, input logic mack);
    bm.xfer(8'hff, mack, rx, ak);
    repeat (4) @(posedge clk_sys);
    chk("slave byte", e, rx);
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    arst_n = 1'b0;
    reg_req = '0;
    arb_lost = 1'b0;
    sleep_deep = 1'b0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    st(8'hf8);
    wr(twsl_pkg::OFS_STATUS, 8'h03);
    rc("prescaler", twsl_pkg::OFS_STATUS, 8'hff, 8'hfb);
    wr(twsl_pkg::OFS_OWN_ADDR, 8'h55);
    rc("own addr", twsl_pkg::OFS_OWN_ADDR, 8'hff, 8'h55);
    wctl(8'h44);
    bm.start();
    send(8'h54, 1'b1);
    rc("flag", twsl_pkg::OFS_CONTROL, 8'h80, 8'h80);
    st(8'h60);
    wctl(8'hc4);
    rc("flag clear", twsl_pkg::OFS_CONTROL, 8'h80, 8'h00);
    send(8'h5a, 1'b1);
    st(8'h80);
    rc("data", twsl_pkg::OFS_DATA, 8'hff, 8'h5a);
    wctl(8'h84);
    send(8'ha5, 1'b0);
    st(8'h88);
    wctl(8'hc4);
    send(8'h11, 1'b0);
    bm.stop();
    bm.start();
    send(8'h00, 1'b1);
    st(8'h70);
    wctl(8'hc4);
    send(8'h3c, 1'b1);
    st(8'h90);
    wctl(8'h84);
    send(8'hc3, 1'b0);
    st(8'h98);
    wctl(8'he4);
    chk("early start", 8'h00, 8'(starts));
    bm.stop();
    chk("start issued", 8'h01, 8'(starts));
    wctl(8'h44);
    bm.start();
    send(8'h55, 1'b1);
    st(8'ha8);
    wr(twsl_pkg::OFS_DATA, 8'hc3);
    wctl(8'hc4);
    recv(8'hc3, 1'b0);
    st(8'hb8);
    wr(twsl_pkg::OFS_DATA, 8'h81);
    wctl(8'h84);
    recv(8'h81, 1'b0);
    st(8'hc8);
    wctl(8'hc4);
    recv(8'hff, 1'b1);
    bm.stop();
    @(posedge clk_sys);
    arb_lost <= 1'b1;
    bm.start();
    send(8'h55, 1'b1);
    st(8'hb0);
    @(posedge clk_sys);
    arb_lost <= 1'b0;
    wr(twsl_pkg::OFS_DATA, 8'h7e);
    wctl(8'hc4);
    recv(8'h7e, 1'b1);
    st(8'hc0);
    wctl(8'hc4);
    bm.stop();
    wctl(8'h04);
    bm.start();
    send(8'h54, 1'b0);
    rc("no flag", twsl_pkg::OFS_CONTROL, 8'h80, 8'h00);
    bm.stop();
    wr(twsl_pkg::OFS_OWN_ADDR, 8'h54);
    wctl(8'h44);
    bm.start();
    send(8'h00, 1'b0);
    bm.stop();
    @(posedge clk_sys);
    sleep_deep <= 1'b1;
    bm.start();
    send(8'h54, 1'b1);
    chk("wake", 8'h01, {7'h0, wake_req});
    repeat (40) @(posedge clk_sys);
    sleep_deep <= 1'b0;
    #1 chk("held", 8'h01, {7'h0, scl_oe});
    wctl(8'hc4);
    @(posedge clk_sys);
    #1 chk("woken", 8'h00, {7'h0, wake_req});
    send(8'h99, 1'b1);
    wctl(8'hc4);
    bm.stop();
    st(8'ha0);
    wctl(8'hc4);
    bm.start();
    send(8'h54, 1'b1);
    stop_test();
  end
endmodule
